// [inc/ccdrd_pkg.sv]
// package: constants and types for the ccd readout timing controller
package ccdrd_pkg;

    // ==================== clock and timing
    localparam int CLK_MHZ         = 40;
    localparam int CLK_PERIOD_PS   = 25000;
    // one register phase step is one clk; a pixel is six steps
    localparam int PIX_STEPS       = 6;
    localparam int PIX_MAX_MHZ     = 36;
    localparam int PIX_RATE_KHZ    = CLK_MHZ * 1000 / PIX_STEPS;
    // vertical step is eight slots, image phase high for five
    localparam int VSTEP_SLOTS     = 8;
    localparam int VSTEP_HIGH      = 5;
    localparam int VSLOT_CYC       = 25;
    localparam int FLUSH_MIN_NS    = 10000;
    localparam int FLUSH_TYP_NS    = 193700;
    localparam int FLUSH_MIN_CYC   =
        (FLUSH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FLUSH_TYP_CYC   =
        (FLUSH_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ==================== geometry
    localparam int FRAME_LINES     = 2060;
    localparam int ACTIVE_LINES    = 2048;
    localparam int LINE_PIXELS     = 3120;
    localparam int ACTIVE_PIXELS   = 3072;
    localparam int OVERSCAN_PIXELS = 8;
    localparam int BLACK_PIXELS    = 40;
    localparam int DUMMY_CELLS     = 14;
    localparam int REG_CELLS       = LINE_PIXELS + DUMMY_CELLS;

    // ==================== software register map
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MODE   = 4'h1;
    localparam logic [3:0] ADDR_BIN    = 4'h2;
    localparam logic [3:0] ADDR_FLUSHT = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_LINE   = 4'h5;
    localparam logic [3:0] ADDR_LINES  = 4'h6;
    localparam logic [3:0] ADDR_CELLS  = 4'h7;
    // ctrl bits
    localparam int CTRL_START  = 0;
    localparam int CTRL_FLUSH  = 1;
    // mode bits
    localparam int MODE_UPPER  = 0;
    localparam int MODE_LOWER  = 1;
    localparam int MODE_LEFT   = 2;
    localparam int MODE_RIGHT  = 3;
    localparam int MODE_ALTFL  = 4;
    localparam int MODE_THREE  = 5;
    localparam logic [5:0]  MODE_RESET  = 6'h0f;
    localparam logic [3:0]  VBIN_RESET  = 4'h1;
    localparam logic [3:0]  HBIN_RESET  = 4'h1;
    localparam logic [23:0] FLUSHT_RESET = 24'(FLUSH_TYP_CYC);
    localparam logic [11:0] LINES_RESET = 12'(FRAME_LINES);
    localparam logic [11:0] CELLS_RESET = 12'(REG_CELLS);

    // ==================== types
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_FLUSH = 5'b00010,
        ST_VERT  = 5'b00100,
        ST_HORZ  = 5'b01000,
        ST_DONE  = 5'b10000
    } ccdrd_state_t;

    // one output register's pins, left or right half
    typedef struct packed {
        logic [2:0] phase;   // register transport phases 1..3
        logic       merge;   // binning merge gate
        logic       clear;   // sense node clear gate
    } ccdrd_half_t;

    // image section pins
    typedef struct packed {
        logic [3:0] xfer_hi;   // image transfer phases at transport high
        logic [3:0] xfer_mid;  // middle transport level, used in two- and three-level clocking
        logic [3:0] flush_lvl; // image phases at charge flush level
        logic       nsub_pulse;// charge flush pulse on n substrate bias
    } ccdrd_image_t;

endpackage : ccdrd_pkg

// [design/ccdrd_hphase.sv]
// module: three-phase register clock and pixel strobes
`timescale 1ns/1ps
module ccdrd_hphase
    import ccdrd_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // control
    input  wire logic       run_i,
    input  wire logic [3:0] hbin_i,
    // outputs
    output logic [2:0]      phase_o,
    output logic            merge_o,
    output logic            clear_o,
    output logic            pix_o
);

    logic [2:0] step_q;
    logic [3:0] bin_q;

    function automatic logic [2:0] ccdrd_phase(input logic [2:0] s);
        // each phase high three of six steps, two steps apart
        ccdrd_phase[0] = (s < 3'd3);
        ccdrd_phase[1] = (s >= 3'd2) && (s < 3'd5);
        ccdrd_phase[2] = (s >= 3'd4) || (s < 3'd1);
    endfunction : ccdrd_phase

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            step_q <= 3'h0;
        end else if (!run_i || step_q == 3'(PIX_STEPS - 1)) begin
            step_q <= 3'h0;
        end else begin
            step_q <= step_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bin_q <= 4'h0;
        end else if (!run_i) begin
            bin_q <= 4'h0;
        end else if (step_q == 3'(PIX_STEPS - 1)) begin
            bin_q <= (bin_q + 4'h1 >= hbin_i) ? 4'h0 : bin_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_o <= 3'h0;
            merge_o <= 1'b0;
            clear_o <= 1'b0;
            pix_o   <= 1'b0;
        end else begin
            // 50 % duty, 120 degree shift
            phase_o <= run_i ? ccdrd_phase(step_q) : 3'b100;
            // merge gate holds charge until the last binned pixel
            merge_o <= run_i && (bin_q + 4'h1 < hbin_i);
            // clear node once per pixel before the packet arrives
            clear_o <= run_i && (step_q == 3'h0);
            pix_o   <= run_i && (step_q == 3'(PIX_STEPS - 1));
        end
    end

    property p_clear_once;
        @(posedge clk_i) disable iff (!arst_n_i)
        clear_o |=> !clear_o [*5];
    endproperty
    a_clear_once: assert property (p_clear_once)
        else $error("clear gate pulsed twice in one pixel");

    property p_duty;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(phase_o[0]) && run_i |=> phase_o[0] [*2] ##1 !phase_o[0];
    endproperty
    a_duty: assert property (p_duty)
        else $error("register phase duty not three of six");

endmodule : ccdrd_hphase

// [design/ccdrd_top.sv]
// module: full frame ccd readout timing controller
`timescale 1ns/1ps
module ccdrd_top
    import ccdrd_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // software port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // sensor pins
    output ccdrd_image_t     image_o,
    output ccdrd_half_t      up_left_o,
    output ccdrd_half_t      up_right_o,
    output ccdrd_half_t      lo_left_o,
    output ccdrd_half_t      lo_right_o,
    // front end
    output logic             pix_valid_o,
    output logic             busy_o
);

    // ==================== registers
    ccdrd_state_t state_q;
    logic [5:0]   mode_q;
    logic [3:0]   vbin_q;
    logic [3:0]   hbin_q;
    logic [23:0]  flusht_q;
    logic [11:0]  lines_q;
    logic [11:0]  cells_q;
    logic         start_q;
    logic         flush_req_q;
    logic [11:0]  line_q;
    logic [3:0]   vcnt_q;
    logic [11:0]  cell_q;
    logic [23:0]  tcnt_q;
    logic [2:0]   slot_q;
    logic         done_q;
    logic         hrun;
    logic [2:0]   hphase;
    logic         hmerge;
    logic         hclear;
    logic         hpix;
    logic [3:0]   flush_floor;

    assign flush_floor = 4'h0;

    // ==================== software writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q   <= MODE_RESET;
            vbin_q   <= VBIN_RESET;
            hbin_q   <= HBIN_RESET;
            flusht_q <= FLUSHT_RESET;
            lines_q  <= LINES_RESET;
            cells_q  <= CELLS_RESET;
        end else if (wr_i && state_q == ST_IDLE) begin
            unique case (addr_i)
                ADDR_MODE: begin
                    mode_q <= wdata_i[5:0];
                end
                ADDR_BIN: begin
                    vbin_q <= (wdata_i[3:0] == 4'h0) ? 4'h1 : wdata_i[3:0];
                    hbin_q <= (wdata_i[7:4] == 4'h0) ? 4'h1 : wdata_i[7:4];
                end
                ADDR_FLUSHT: begin
                    // never shorter than the least flush time
                    flusht_q <= (wdata_i[23:0] < 24'(FLUSH_MIN_CYC))
                        ? 24'(FLUSH_MIN_CYC) : wdata_i[23:0];
                end
                ADDR_LINES: begin
                    lines_q <= (wdata_i[11:0] == 12'h0)
                        ? LINES_RESET : wdata_i[11:0];
                end
                ADDR_CELLS: begin
                    // never fewer than one full register of transfers
                    cells_q <= (wdata_i[11:0] < CELLS_RESET)
                        ? CELLS_RESET : wdata_i[11:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q     <= 1'b0;
            flush_req_q <= 1'b0;
        end else begin
            start_q     <= wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_START];
            flush_req_q <= wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_FLUSH];
        end
    end

    // ==================== software reads
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_MODE:   rdata_o <= {26'h0, mode_q};
                ADDR_BIN:    rdata_o <= {24'h0, hbin_q, vbin_q};
                ADDR_FLUSHT: rdata_o <= {8'h0, flusht_q};
                ADDR_STATUS: rdata_o <= {26'h0, done_q, state_q};
                ADDR_LINE:   rdata_o <= {20'h0, line_q};
                ADDR_LINES:  rdata_o <= {20'h0, lines_q};
                ADDR_CELLS:  rdata_o <= {20'h0, cells_q};
                default:     rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // ==================== sequencer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            tcnt_q  <= 24'h0;
            slot_q  <= 3'h0;
            line_q  <= 12'h0;
            vcnt_q  <= 4'h0;
            cell_q  <= 12'h0;
            done_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    tcnt_q <= 24'h0;
                    slot_q <= 3'h0;
                    if (flush_req_q) begin
                        state_q <= ST_FLUSH;
                        done_q  <= 1'b0;
                    end else if (start_q) begin
                        state_q <= ST_VERT;
                        line_q  <= 12'h0;
                        vcnt_q  <= 4'h0;
                        done_q  <= 1'b0;
                    end
                end
                ST_FLUSH: begin
                    // hold flush for the programmed time
                    if (tcnt_q + 24'h1 >= flusht_q) begin
                        state_q <= ST_DONE;
                    end
                    tcnt_q <= tcnt_q + 24'h1;
                end
                ST_VERT: begin
                    // one line shift: eight slots of slot length
                    if (tcnt_q == 24'(VSLOT_CYC - 1)) begin
                        tcnt_q <= 24'h0;
                        slot_q <= slot_q + 3'h1;
                        if (slot_q == 3'(VSTEP_SLOTS - 1)) begin
                            line_q <= line_q + 12'h1;
                            // sum lines before reading out
                            if (vcnt_q + 4'h1 >= vbin_q ||
                                line_q + 12'h1 >= lines_q) begin
                                vcnt_q  <= 4'h0;
                                cell_q  <= 12'h0;
                                state_q <= ST_HORZ;
                            end else begin
                                vcnt_q <= vcnt_q + 4'h1;
                            end
                        end
                    end else begin
                        tcnt_q <= tcnt_q + 24'h1;
                    end
                end
                ST_HORZ: begin
                    // empty the whole register before next shift
                    if (hpix) begin
                        cell_q <= cell_q + 12'h1;
                        if (cell_q + 12'h1 >= cells_q) begin
                            state_q <= (line_q >= lines_q)
                                ? ST_DONE : ST_VERT;
                        end
                    end
                end
                ST_DONE: begin
                    done_q  <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign hrun = (state_q == ST_HORZ);

    ccdrd_hphase i_ccdrd_hphase (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .run_i    (hrun),
        .hbin_i   (hbin_q),
        .phase_o  (hphase),
        .merge_o  (hmerge),
        .clear_o  (hclear),
        .pix_o    (hpix)
    );

    // ==================== image section pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            image_o <= '0;
        end else begin
            image_o <= '0;
            if (state_q == ST_VERT) begin
                // each phase high five of eight slots, staggered
                for (int i = 0; i < 4; i++) begin
                    image_o.xfer_hi[i] <= mode_q[MODE_THREE] &&
                        (3'(slot_q - 3'(2 * i)) < 3'(VSTEP_HIGH));
                    image_o.xfer_mid[i] <=
                        (3'(slot_q - 3'(2 * i)) < 3'(VSTEP_HIGH));
                end
            end else if (state_q == ST_FLUSH) begin
                if (mode_q[MODE_ALTFL]) begin
                    image_o.flush_lvl <= 4'hf;
                end else begin
                    image_o.flush_lvl  <= flush_floor;
                    image_o.nsub_pulse <= 1'b1;
                end
            end
        end
    end

    // ==================== register pins
    function automatic ccdrd_half_t ccdrd_half(input logic en,
                                              input logic vert);
        ccdrd_half_t h;
        h = '0;
        if (vert) begin
            // third phase high keeps arriving packets apart
            h.phase = 3'b100;
        end else if (en && state_q == ST_HORZ) begin
            // the half-started step after the last pixel is never driven
            h.phase = hphase;
            h.merge = hmerge;
            h.clear = hclear;
        end
        ccdrd_half = h;
    endfunction : ccdrd_half

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_left_o  <= '0;
            up_right_o <= '0;
            lo_left_o  <= '0;
            lo_right_o <= '0;
        end else begin
            // halves enabled separately
            up_left_o  <= ccdrd_half(mode_q[MODE_UPPER] &&
                mode_q[MODE_LEFT], state_q == ST_VERT);
            up_right_o <= ccdrd_half(mode_q[MODE_UPPER] &&
                mode_q[MODE_RIGHT], state_q == ST_VERT);
            lo_left_o  <= ccdrd_half(mode_q[MODE_LOWER] &&
                mode_q[MODE_LEFT], state_q == ST_VERT);
            lo_right_o <= ccdrd_half(mode_q[MODE_LOWER] &&
                mode_q[MODE_RIGHT], state_q == ST_VERT);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pix_valid_o <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            // pixel rate 40/6 MHz stays under the limit
            pix_valid_o <= hpix &&
                (PIX_RATE_KHZ <= PIX_MAX_MHZ * 1000);
            busy_o      <= state_q != ST_IDLE;
        end
    end

    // ==================== checks
    property p_flush_len;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(state_q == ST_FLUSH) |-> tcnt_q == 24'h0 && flusht_q >=
            24'(FLUSH_MIN_CYC);
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush shorter than least time");

    property p_vert_third;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_VERT |=> up_left_o.phase == 3'b100 &&
            lo_right_o.phase == 3'b100;
    endproperty
    a_vert_third: assert property (p_vert_third)
        else $error("third phase not held in vertical transport");

    property p_no_shift_in_horz;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_HORZ |=> image_o.xfer_mid == 4'h0;
    endproperty
    a_no_shift_in_horz: assert property (p_no_shift_in_horz)
        else $error("line shift during horizontal readout");

    property p_flush_method;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_FLUSH && !mode_q[MODE_ALTFL] |=>
            image_o.nsub_pulse && image_o.flush_lvl == 4'h0;
    endproperty
    a_flush_method: assert property (p_flush_method)
        else $error("preferred flush not driven");

    property p_alt_flush;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_FLUSH && mode_q[MODE_ALTFL] |=>
            !image_o.nsub_pulse && image_o.flush_lvl == 4'hf;
    endproperty
    a_alt_flush: assert property (p_alt_flush)
        else $error("alternative flush not driven");

    property p_line_bound;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_DONE && $past(state_q) == ST_HORZ |-> line_q == lines_q;
    endproperty
    a_line_bound: assert property (p_line_bound)
        else $error("frame ended with wrong line count");

    property p_cells;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q != ST_HORZ && $past(state_q) == ST_HORZ |->
            cell_q >= 12'(REG_CELLS);
    endproperty
    a_cells: assert property (p_cells)
        else $error("register readout too short");

    property p_half_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        state_q == ST_HORZ && !mode_q[MODE_RIGHT] |=>
            up_right_o.phase == 3'h0 && lo_right_o.phase == 3'h0;
    endproperty
    a_half_off: assert property (p_half_off)
        else $error("disabled right half clocked");

endmodule : ccdrd_top

// [dv/ccdrd_sensor_model.sv]
// sensor side model: tallies what the timing pins do
`timescale 1ns/1ps
module ccdrd_sensor_model
    import ccdrd_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // pins from the controller
    input  wire logic         clr_i,
    input  ccdrd_image_t      image_i,
    input  ccdrd_half_t [3:0] half_i,
    input  wire logic         pix_i,
    // tallies
    output logic [31:0]       cnt_o [0:11]
);
    // ==================== line and pixel tallies
    logic        v_q;
    logic        c_q;
    logic [31:0] gap_q;
    wire  logic  v = image_i.xfer_mid[0] | image_i.xfer_hi[0];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i || clr_i) begin
            for (int i = 0; i < 12; i++) begin
                cnt_o[i] <= (i == 9) ? 32'h0000ffff : 32'h0;
            end
            v_q   <= 1'b0;
            c_q   <= 1'b0;
            gap_q <= 32'h0;
        end else begin
            v_q <= v;
            c_q <= half_i[0].clear;
            cnt_o[0] <= cnt_o[0] + 32'(v & !v_q);
            cnt_o[1] <= cnt_o[1] + 32'(v);
            for (int h = 0; h < 4; h++) begin
                cnt_o[2+h] <= cnt_o[2+h] + 32'(half_i[h].phase[0]);
            end
            cnt_o[6] <= cnt_o[6] + 32'(half_i[0].clear & !c_q);
            cnt_o[7] <= cnt_o[7] + 32'(image_i.nsub_pulse);
            cnt_o[8] <= cnt_o[8] + 32'(&image_i.flush_lvl);
            gap_q <= pix_i ? 32'h1 : gap_q + 32'h1;
            if (pix_i && cnt_o[10] != 0 && gap_q < cnt_o[9]) begin
                cnt_o[9] <= gap_q;
            end
            cnt_o[10] <= cnt_o[10] + 32'(pix_i);
            cnt_o[11] <= cnt_o[11] + 32'(half_i[0].merge);
        end
    end
endmodule : ccdrd_sensor_model

// [dv/ccdrd_top_bench.sv]
// testbench for the ccd readout timing controller
`timescale 1ns/1ps
module ccdrd_top_bench;
    import ccdrd_pkg::*;
    // ==================== signals
    logic              clk_i;
    logic              arst_n_i;
    logic              wr_i;
    logic              rd_i;
    logic              clr;
    logic [3:0]        addr_i;
    logic [31:0]       wdata_i;
    logic [31:0]       rdata_o;
    logic [31:0]       d;
    ccdrd_image_t      image_o;
    ccdrd_half_t       up_left_o;
    ccdrd_half_t       up_right_o;
    ccdrd_half_t       lo_left_o;
    ccdrd_half_t       lo_right_o;
    ccdrd_half_t [3:0] halves;
    logic              pix_valid_o;
    logic              busy_o;
    logic [31:0]       cnt [0:11];
    logic [5:0]        m;
    int                failures;
    int                checks;
    int                cyc;
    int                vb;
    int                hb;
    logic [31:0]       px;
    logic [3:0]  ra [0:6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
    logic [31:0] rv [0:6] = '{32'hf, 32'h11, 32'h1e44, 32'h1, 32'h80c,
                              32'hc3e, 32'h0};

    assign halves = {lo_right_o, lo_left_o, up_right_o, up_left_o};

    ccdrd_top i_ccdrd_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .image_o(image_o), .up_left_o(up_left_o), .up_right_o(up_right_o),
        .lo_left_o(lo_left_o), .lo_right_o(lo_right_o),
        .pix_valid_o(pix_valid_o), .busy_o(busy_o));

    ccdrd_sensor_model i_ccdrd_sensor_model (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .clr_i(clr),
        .image_i(image_o), .half_i(halves), .pix_i(pix_valid_o),
        .cnt_o(cnt));

    // ==================== tasks
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t exp %0h got %0h", $time, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask : rd

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 60000) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 60000) begin
            failures++;
            $display("MISMATCH t=%0t frame never finished", $time);
        end
        @(posedge clk_i);
    endtask : wait_idle

    task automatic zero_tally;
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
    endtask : zero_tally

    function automatic logic en(input logic [5:0] md, input int h);
        return md[h/2] & md[2 + h%2];
    endfunction : en

    // merge gate cycles over two passes: all but the last pixel of a group
    function automatic logic [31:0] mrg(input int c, input int b);
        return 32'(2 * PIX_STEPS * (c - c / b));
    endfunction : mrg

    task automatic test_done;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ==================== clock and timeout
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            failures++;
            $display("MISMATCH t=%0t cycle limit reached", $time);
            test_done();
        end
    end

    // ==================== main sequence
    initial begin
        arst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; clr = 1'b0;
        addr_i = 4'h0; wdata_i = 32'h0; failures = 0; checks = 0; cyc = 0;
        void'($urandom(41554));
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], d);
            chk(rv[i], d);
        end
        // random frame: binning, halves, clock levels
        vb = 1 + $urandom % 2;
        hb = 1 + $urandom % 3;
        m = {1'($urandom), 1'b0, 2'(1 + $urandom % 3), 2'(1 + $urandom % 3)};
        px = 32'(2 * REG_CELLS);
        wr(ADDR_MODE, 32'(m));
        wr(ADDR_BIN, 32'({4'(hb), 4'(vb)}));
        wr(ADDR_LINES, 32'(2 * vb));
        zero_tally();
        wr(ADDR_CTRL, 32'h1);
        repeat (4) @(posedge clk_i);
        wr(ADDR_LINES, 32'h7);
        wait_idle();
        rd(ADDR_LINES, d);
        chk(32'(2 * vb), d);
        rd(ADDR_STATUS, d);
        chk(32'h21, d);
        chk(32'(2 * vb), cnt[0]);
        chk(32'(250 * vb), cnt[1]);
        for (int h = 0; h < 4; h++) begin
            chk(en(m, h) ? 3 * px : 32'h0, cnt[2+h]);
        end
        chk(en(m, 0) ? px : 32'h0, cnt[6]);
        chk(en(m, 0) ? mrg(REG_CELLS, hb) : 32'h0, cnt[11]);
        chk(px, cnt[10]);
        chk(32'h6, cnt[9]);
        // both flush methods, start asked beside flush
        for (int a = 0; a < 2; a++) begin
            wr(ADDR_MODE, a ? 32'h1f : 32'h0f);
            wr(ADDR_FLUSHT, 32'h190);
            zero_tally();
            wr(ADDR_CTRL, 32'h3);
            repeat (4) @(posedge clk_i);
            wait_idle();
            chk(32'(a == 0), 32'(cnt[7] >= 400));
            chk(32'(a == 1), 32'(cnt[8] >= 400));
            chk(32'h0, cnt[1]);
        end
        // reset while idle, after the flushes, restores defaults
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(ADDR_MODE, d);
        chk(32'hf, d);
        rd(ADDR_STATUS, d);
        chk(32'h1, d);
        test_done();
    end
endmodule : ccdrd_top_bench
